//--- design/rtc_alarm_timer_consts.vh
// Register indices, field positions, reset values and timing for the block
`ifndef RTC_ALARM_TIMER_CONSTS_VH
`define RTC_ALARM_TIMER_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_DATE_ALARM 10'h00a
`define IDX_PRESET_LOW 10'h00b
`define IDX_PRESET_HIGH 10'h00c
`define IDX_TIMER_CTRL 10'h010
`define IDX_IRQ_STATUS 10'h011
`define IDX_IRQ_MASK 10'h012
`define IDX_COUNT_NOW 10'h013

// Date alarm fields
`define DATE_ENABLE_N_BIT 7
`define DATE_VALUE_MSB 5
`define DATE_VALUE_RESET 6'h00
`define DATE_ENABLE_N_RESET 1'b0

// Timer preset fields
`define PRESET_LOW_RESET 8'h00
`define PRESET_HIGH_RESET 4'h0
`define PRESET_WIDTH 12

// Timer control fields
`define CTRL_RUN_BIT 0
`define CTRL_SEL_LSB 1
`define CTRL_SEL_MSB 2
`define CTRL_RESET 3'h0

// Interrupt status and mask bits
`define IRQ_TIMER_BIT 0
`define IRQ_REFUSED_BIT 1
`define IRQ_RESET 2'h0

// Timer clock choices, as periods in ns of the timer tick
`define CLK_PERIOD_NS 100
`define TICK0_NS 100
`define TICK1_NS 1000
`define TICK2_NS 10000
`define TICK3_NS 100000

`endif

//--- design/timer_tick_divider.v
// Selectable divider making the one-cycle timer clock enable
`timescale 1ns/10ps
module timer_tick_divider #(
  parameter DIV0 = 1,
  parameter DIV1 = 10,
  parameter DIV2 = 100,
  parameter DIV3 = 1000,
  parameter CW = 10
) (
  input wire hclk,
  input wire hresetn,
  input wire run,
  input wire [1:0] sel,
  output reg tick
);

  reg [CW-1:0] count;
  reg [CW-1:0] limit;

  // Terminal count for the selected rate
  always @* begin
    case (sel)
      2'h0: limit = DIV0[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      2'h1: limit = DIV1[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      2'h2: limit = DIV2[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      default: limit = DIV3[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
    endcase
  end

  // Restart from zero whenever stopped, so the first period is whole
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      count <= {CW{1'b0}};
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= {CW{1'b0}};
      tick <= 1'b1;
    end else begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule // timer_tick_divider

//--- design/countdown_core.v
// Twelve-bit auto-reloading countdown counter
`timescale 1ns/10ps
module countdown_core #(
  parameter W = 12
) (
  input wire hclk,
  input wire hresetn,
  input wire run,
  input wire tick,
  input wire [W-1:0] preset,
  output reg [W-1:0] count,
  output reg expired
);

  // Load while stopped; count down on ticks; reload on the tick that finds one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= {W{1'b0}};
      expired <= 1'b0;
    end else if (!run) begin
      count <= preset;
      expired <= 1'b0;
    end else if (tick) begin
      if (count <= {{(W-1){1'b0}}, 1'b1}) begin
        // A zero preset never expires, it just holds
        count <= preset;
        expired <= (preset != {W{1'b0}});
      end else begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
        expired <= 1'b0;
      end
    end else begin
      expired <= 1'b0;
    end
  end

endmodule // countdown_core

//--- design/rtc_alarm_timer.v
// Date alarm and periodic countdown timer registers behind AHB-Lite
`timescale 1ns/10ps
`include "rtc_alarm_timer_consts.vh"
module rtc_alarm_timer #(
  parameter DIV0 = `TICK0_NS / `CLK_PERIOD_NS,
  parameter DIV1 = `TICK1_NS / `CLK_PERIOD_NS,
  parameter DIV2 = `TICK2_NS / `CLK_PERIOD_NS,
  parameter DIV3 = `TICK3_NS / `CLK_PERIOD_NS
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire write_protect,
  output reg [5:0] date_alarm_value,
  output reg date_alarm_enable_n,
  output wire timer_expired,
  output reg irq
);

  // Bus phase state
  reg wr_pend;
  reg rd_pend;
  reg [9:0] ph_idx;
  reg ph_ok;

  // Register contents
  reg [7:0] preset_low;
  reg [3:0] preset_high;
  reg [2:0] timer_ctrl;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;

  wire [11:0] count_now;
  wire tick;
  wire [`PRESET_WIDTH-1:0] preset;
  wire addr_phase;
  wire wr_now;
  wire guarded;
  reg [31:0] read_mux;
  reg [1:0] next_irq_status;

  // Full preset from both registers
  assign preset = {preset_high, preset_low};

  // Only single word transfers are answered; other sizes are ignored
  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_now = wr_pend & ph_ok;
  assign guarded = (ph_idx == `IDX_DATE_ALARM) |
                   (ph_idx == `IDX_PRESET_LOW) |
                   (ph_idx == `IDX_PRESET_HIGH);

  // Capture the address phase; reads get one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_idx <= 10'h000;
      ph_ok <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_pend) begin
        rd_pend <= 1'b0;
        hreadyout <= 1'b1;
      end else begin
        wr_pend <= addr_phase & hwrite;
        rd_pend <= addr_phase & ~hwrite;
        hreadyout <= ~(addr_phase & ~hwrite);
        if (addr_phase) begin
          ph_idx <= haddr[11:2];
          ph_ok <= (haddr[31:12] == 20'h00000) &
                   (haddr[1:0] == 2'h0) & (hsize == 3'h2);
        end
      end
    end
  end

  // Read data mux, unused bits read as zero
  always @* begin
    read_mux = 32'h00000000;
    if (ph_ok) begin
      case (ph_idx)
        `IDX_DATE_ALARM:
          read_mux[7:0] = {date_alarm_enable_n, 1'b0,
                           date_alarm_value};
        `IDX_PRESET_LOW: read_mux[7:0] = preset_low;
        `IDX_PRESET_HIGH: read_mux[3:0] = preset_high;
        `IDX_TIMER_CTRL: read_mux[2:0] = timer_ctrl;
        `IDX_IRQ_STATUS: read_mux[1:0] = irq_status;
        `IDX_IRQ_MASK: read_mux[1:0] = irq_mask;
        `IDX_COUNT_NOW: read_mux[11:0] = count_now;
        default: read_mux = 32'h00000000;
      endcase
    end
  end

  // Read data is loaded in the wait cycle, after any earlier write landed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend) begin
      hrdata <= read_mux;
    end
  end

  // Protected registers: writes dropped while protection is on
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      date_alarm_value <= `DATE_VALUE_RESET;
      date_alarm_enable_n <= `DATE_ENABLE_N_RESET;
      preset_low <= `PRESET_LOW_RESET;
      preset_high <= `PRESET_HIGH_RESET;
    end else if (wr_now & ~write_protect) begin
      case (ph_idx)
        `IDX_DATE_ALARM: begin
          date_alarm_value <= hwdata[`DATE_VALUE_MSB:0];
          date_alarm_enable_n <= hwdata[`DATE_ENABLE_N_BIT];
        end
        `IDX_PRESET_LOW: preset_low <= hwdata[7:0];
        `IDX_PRESET_HIGH: preset_high <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // Unprotected control and mask registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_ctrl <= `CTRL_RESET;
      irq_mask <= `IRQ_RESET;
    end else if (wr_now) begin
      if (ph_idx == `IDX_TIMER_CTRL) begin
        timer_ctrl <= hwdata[2:0];
      end
      if (ph_idx == `IDX_IRQ_MASK) begin
        irq_mask <= hwdata[1:0];
      end
    end
  end

  // Sticky events: write one to clear, a new event wins over the clear
  always @* begin
    next_irq_status = irq_status;
    if (wr_now & (ph_idx == `IDX_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~hwdata[1:0];
    end
    if (timer_expired) begin
      next_irq_status[`IRQ_TIMER_BIT] = 1'b1;
    end
    if (wr_now & write_protect & guarded) begin
      next_irq_status[`IRQ_REFUSED_BIT] = 1'b1;
    end
  end

  // Status and interrupt line, both registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= `IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // Tick rate sets the period: preset ticks per expiry
  timer_tick_divider #(
    .DIV0(DIV0),
    .DIV1(DIV1),
    .DIV2(DIV2),
    .DIV3(DIV3),
    .CW(10)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(timer_ctrl[`CTRL_RUN_BIT]),
    .sel(timer_ctrl[`CTRL_SEL_MSB:`CTRL_SEL_LSB]),
    .tick(tick)
  );

  countdown_core #(
    .W(`PRESET_WIDTH)
  ) u_count (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(timer_ctrl[`CTRL_RUN_BIT]),
    .tick(tick),
    .preset(preset),
    .count(count_now),
    .expired(timer_expired)
  );

endmodule // rtc_alarm_timer

//--- test/ahb_host.sv
// AHB-Lite host model issuing single word transfers
`timescale 1ns/10ps
module ahb_host (
  input wire hclk,
  input wire hready,
  input wire [31:0] hrdata,
  output reg hsel,
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Called just after an edge; waits as long as the slave stalls
  task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= w ? d : ~hwdata;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      q = hrdata;
      hwdata <= ~hwdata; // Stale data never looks valid
    end
  endtask
endmodule // ahb_host

//--- test/rtc_alarm_timer_assertions.sv
// Bus and register assertions for the alarm and timer block
`timescale 1ns/10ps
module rtc_alarm_timer_assertions (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire write_protect,
  input wire [5:0] date_alarm_value,
  input wire date_alarm_enable_n
);
  // Accepted word transfers
  wire acc = hsel & htrans[1] & hready & (hsize == 3'h2);
  wire rd = acc & !hwrite;
  wire wr_date = acc & hwrite & (haddr == 32'h28);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bad response");
  read_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  write_nowait_a: assert property (acc && hwrite |=> hreadyout)
    else $error("write stalled");
  date_store_a: assert property (wr_date ##1 !write_protect |=>
    date_alarm_value == $past(hwdata[5:0]) &&
    date_alarm_enable_n == $past(hwdata[7])) else $error("date not stored");
  protect_hold_a: assert property (wr_date ##1 write_protect |=>
    $stable(date_alarm_value) && $stable(date_alarm_enable_n))
    else $error("protected write landed");
  date_read_a: assert property (rd && haddr == 32'h28 |=> ##1
    hrdata == {24'h0, date_alarm_enable_n, 1'b0, date_alarm_value})
    else $error("date read wrong");
  low_zero_a: assert property (rd && haddr == 32'h2c |=> ##1
    hrdata[31:8] == 24'h0) else $error("low preset wide");
  high_zero_a: assert property (rd && haddr == 32'h30 |=> ##1
    hrdata[31:4] == 28'h0) else $error("high preset wide");
endmodule // rtc_alarm_timer_assertions

bind rtc_alarm_timer rtc_alarm_timer_assertions
  rtc_alarm_timer_assertions_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .write_protect, .date_alarm_value, .date_alarm_enable_n);

//--- test/tb.sv
// Self-checking bench for the date alarm and countdown timer
`timescale 1ns/10ps
`include "rtc_alarm_timer_consts.vh"
module tb;
  localparam div1 = 4; // Short tick keeps periods brief
  localparam [31:0] a_date = `IDX_DATE_ALARM * 4;
  localparam [31:0] a_plo = `IDX_PRESET_LOW * 4;
  localparam [31:0] a_phi = `IDX_PRESET_HIGH * 4;
  localparam [31:0] a_ctrl = `IDX_TIMER_CTRL * 4;
  localparam [31:0] a_st = `IDX_IRQ_STATUS * 4;
  localparam [31:0] a_mk = `IDX_IRQ_MASK * 4;
  localparam [31:0] a_cnt = `IDX_COUNT_NOW * 4;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg write_protect = 1'b0;
  wire hsel, hwrite, hreadyout, hresp, irq, timer_expired;
  wire date_alarm_enable_n;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata;
  wire [5:0] date_alarm_value;
  integer n_fail = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer t0, t1, t2;
  reg [31:0] q, q0;

  // 100 ns clock and a cycle count
  always #50 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  rtc_alarm_timer #(.DIV1(div1)) rtc_alarm_timer_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .write_protect(write_protect), .date_alarm_value(date_alarm_value),
    .date_alarm_enable_n(date_alarm_enable_n),
    .timer_expired(timer_expired), .irq(irq));
  ahb_host ahb_host_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  task check(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    ahb_host_inst.xfer(1'b1, a, d, q);
  endtask
  task rd(input [31:0] a);
    ahb_host_inst.xfer(1'b0, a, 32'h0, q);
  endtask
  task wait_exp;
    begin
      @(posedge hclk);
      while (timer_expired !== 1'b1) @(posedge hclk);
    end
  endtask

  task t_reset;
    begin
      rd(a_date);
      check(q, 32'h0);
      rd(a_plo);
      check(q, 32'h0);
      rd(a_phi);
      check(q, 32'h0);
    end
  endtask
  // Bit 6 and bits 31:8 must drop; value 0x31 is a legal value
  task t_regs;
    begin
      wr(a_date, 32'hffff_fff1);
      rd(a_date);
      check(q, 32'hb1);
      check(date_alarm_enable_n, 1'b1);
      wr(a_plo, 32'hffff_ffa5);
      rd(a_plo);
      check(q, 32'ha5);
      wr(a_phi, 32'hffff_ffff);
      rd(a_phi);
      check(q, 32'hf);
    end
  endtask
  // Refused writes raise a maskable event; stored values must survive
  task t_protect;
    begin
      write_protect <= 1'b1;
      wr(a_plo, 32'h5a);
      wr(a_date, 32'h05);
      write_protect <= 1'b0;
      rd(a_plo);
      check(q, 32'ha5);
      rd(a_date);
      check(q, 32'hb1);
      rd(a_st);
      check(q, 32'h2);
      check(irq, 1'b0);
      wr(a_mk, 32'h2);
      rd(a_st);
      check(irq, 1'b1);
      wr(a_st, 32'h3);
      rd(a_st);
      check(irq, 1'b0);
    end
  endtask
  // Preset 0x103 must repeat every 259 ticks
  task t_timer;
    begin
      wr(a_plo, 32'h3);
      wr(a_phi, 32'h1);
      wr(a_mk, 32'h1);
      wr(a_ctrl, 32'h3);
      wait_exp;
      t0 = cyc;
      wait_exp;
      t1 = cyc;
      wait_exp;
      t2 = cyc;
      check(t1 - t0, 259 * div1);
      check(t2 - t1, 259 * div1);
      rd(a_st);
      check(q, 32'h1);
      check(irq, 1'b1);
      wr(a_ctrl, 32'h0);
      wr(a_st, 32'h1);
      rd(a_st);
      check(q, 32'h0);
    end
  endtask
  // One tick per cycle, so the drop equals the cycles between reads
  task t_count;
    begin
      wr(a_plo, 32'hff);
      wr(a_phi, 32'hf);
      rd(a_cnt);
      check(q, 32'hfff);
      wr(a_ctrl, 32'h1);
      t0 = cyc;
      rd(a_cnt);
      q0 = q;
      repeat (20) @(posedge hclk);
      t1 = cyc;
      rd(a_cnt);
      check(q0 - q, t1 - t0);
      wr(a_ctrl, 32'h0);
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // Whole run is a few thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_regs;
    t_protect;
    t_timer;
    t_count;
    print_verdict;
  end
endmodule // tb
